// file: verilog/pcc_pkg.sv
// Constants, field layouts and carrier types of the position compare counter.
package pcc_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses, low byte of haddr)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] PERIOD_OFF  = 8'h04;
    localparam logic [7:0] COMPARE_OFF = 8'h08;
    localparam logic [7:0] COUNT_OFF   = 8'h0c;
    localparam logic [7:0] STATUS_OFF  = 8'h10;
    localparam logic [7:0] MASK_OFF    = 8'h14;

    // ----------------------------------------------------------------
    // Field positions and widths
    // ----------------------------------------------------------------
    localparam int CTRL_W         = 5;
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_CMPEN_BIT = 2;
    localparam int CTRL_INTEN_BIT = 3;
    localparam int CTRL_IDXEN_BIT = 4;
    localparam int STAT_W         = 2;
    localparam int STAT_MATCH_BIT = 0;
    localparam int STAT_PULSE_BIT = 1;
    localparam int CNT_W          = 24;
    localparam int LOW_W          = 16;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [4:0]  CTRL_RST    = 5'h00;
    localparam logic [15:0] PERIOD_RST  = 16'h0000;
    localparam logic [23:0] COMPARE_RST = 24'h000000;
    localparam logic [23:0] COUNT_RST   = 24'h000000;
    localparam logic [1:0]  STAT_RST    = 2'h0;
    localparam logic [1:0]  MASK_RST    = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ENCODER,
        MODE_SENSOR_EVENT,
        MODE_SENSOR_TIMER,
        MODE_TIMER
    } pcc_mode_type;

    typedef struct packed {
        logic         idx_en;
        logic         int_en;
        logic         cmp_en;
        pcc_mode_type mode;
    } pcc_ctrl_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } pcc_aphase_type;

endpackage

// file: verilog/pcc_position_compare_counter.sv
// Position compare counter with an AHB-Lite register slave.
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

module pcc_position_compare_counter (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Position input from the decoder on hclk
    input  wire logic        quadrature_count_pulse,
    input  wire logic        rotation_ccw,
    // Interrupt
    output logic             position_unit_irq
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    pcc_pkg::pcc_aphase_type ap_q;
    pcc_pkg::pcc_aphase_type ap_d;
    pcc_pkg::pcc_ctrl_type   ctrl_q;
    logic [15:0]             period_q;
    logic [23:0]             cmp_q;
    logic [23:0]             cnt_q;
    logic [23:0]             cnt_d;
    logic [1:0]              stat_q;
    logic [1:0]              stat_d;
    logic [1:0]              mask_q;
    logic                    upd_q;
    logic [31:0]             rd_d;

    wire        take    = hsel & htrans[1] & hready;
    wire        rd_take = take & ~hwrite & (hsize == pcc_pkg::HSIZE_WORD);
    wire [7:0]  ra      = haddr[7:0];
    wire        wr      = ap_q.valid & ap_q.write;
    wire        wr_ctrl = wr & reg_hit(ap_q.addr, pcc_pkg::CTRL_OFF);
    wire        wr_per  = wr & reg_hit(ap_q.addr, pcc_pkg::PERIOD_OFF);
    wire        wr_cmp  = wr & reg_hit(ap_q.addr, pcc_pkg::COMPARE_OFF);
    wire        wr_cnt  = wr & reg_hit(ap_q.addr, pcc_pkg::COUNT_OFF);
    wire        wr_stat = wr & reg_hit(ap_q.addr, pcc_pkg::STATUS_OFF);
    wire        wr_mask = wr & reg_hit(ap_q.addr, pcc_pkg::MASK_OFF);

    assign ap_d = '{addr:  haddr[7:0],
                    write: hwrite,
                    valid: take & (hsize == pcc_pkg::HSIZE_WORD)};

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    wire        wide  = (ctrl_q.mode == pcc_pkg::MODE_SENSOR_TIMER) |
                        (ctrl_q.mode == pcc_pkg::MODE_TIMER);
    wire [15:0] cnt16 = cnt_q[15:0];
    wire [15:0] enc_n = rotation_ccw ? ((cnt16 == 16'h0000) ? period_q : cnt16 - 16'h0001)
                                     : ((cnt16 == period_q) ? 16'h0000 : cnt16 + 16'h0001);
    wire [15:0] evt_n = rotation_ccw ? cnt16 - 16'h0001 : cnt16 + 16'h0001;
    wire [23:0] inc_n = cnt_q + 24'h000001;
    wire [23:0] step  =
        (ctrl_q.mode == pcc_pkg::MODE_ENCODER)      ? {8'h00, enc_n} :
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_EVENT) ? {8'h00, evt_n} :
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_TIMER && quadrature_count_pulse) ?
                                                      pcc_pkg::COUNT_RST : inc_n;
    wire        adv   = wide | quadrature_count_pulse;

    // A software write wins over the hardware step and is not itself a compare event.
    assign cnt_d = wr_cnt ? hwdata[pcc_pkg::CNT_W-1:0] : (adv ? step : cnt_q);

    // In the 16-bit modes the upper byte of the count always reads zero.
    wire [23:0] cnt_view = wide ? cnt_q : {8'h00, cnt16};

    // ----------------------------------------------------------------
    // Compare and interrupt
    // ----------------------------------------------------------------
    // The compare looks at the counter only in the cycle after it moved, so a
    // counter that rests on the compare value does not raise a second event.
    wire cmp_eq    = wide ? (cnt_q == cmp_q)
                          : (cnt16 == cmp_q[pcc_pkg::LOW_W-1:0]);
    wire match_evt = upd_q & ctrl_q.cmp_en & cmp_eq;

    wire [1:0] evt   = {quadrature_count_pulse, match_evt};
    wire [1:0] clr   = wr_stat ? hwdata[pcc_pkg::STAT_W-1:0] : 2'h0;
    assign stat_d    = (stat_q & ~clr) | evt;

    // The index enable stays out of this term on purpose.
    wire [1:0] gate  = {1'b1, ctrl_q.int_en};
    wire       irq_d = |(stat_q & mask_q & gate);

    assign rd_d =
        !rd_take                         ? 32'h00000000 :
        reg_hit(ra, pcc_pkg::CTRL_OFF)    ? {27'h0000000, ctrl_q} :
        reg_hit(ra, pcc_pkg::PERIOD_OFF)  ? {16'h0000, period_q} :
        reg_hit(ra, pcc_pkg::COMPARE_OFF) ? {8'h00, cmp_q} :
        reg_hit(ra, pcc_pkg::COUNT_OFF)   ? {8'h00, cnt_view} :
        reg_hit(ra, pcc_pkg::STATUS_OFF)  ? {30'h00000000, stat_q} :
        reg_hit(ra, pcc_pkg::MASK_OFF)    ? {30'h00000000, mask_q} :
                                            32'h00000000;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q      <= '0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            ap_q      <= ap_d;
            hrdata    <= rd_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q   <= pcc_pkg::pcc_ctrl_type'(pcc_pkg::CTRL_RST);
            period_q <= pcc_pkg::PERIOD_RST;
            cmp_q    <= pcc_pkg::COMPARE_RST;
            mask_q   <= pcc_pkg::MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pcc_pkg::pcc_ctrl_type'(hwdata[pcc_pkg::CTRL_W-1:0]);
            end
            if (wr_per) begin
                period_q <= hwdata[15:0];
            end
            if (wr_cmp) begin
                cmp_q <= hwdata[pcc_pkg::CNT_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= hwdata[pcc_pkg::STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q             <= pcc_pkg::COUNT_RST;
            upd_q             <= 1'b0;
            stat_q            <= pcc_pkg::STAT_RST;
            position_unit_irq <= 1'b0;
        end else begin
            cnt_q             <= cnt_d;
            upd_q             <= adv & ~wr_cnt;
            stat_q            <= stat_d;
            position_unit_irq <= irq_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_cnt_moved;
        upd_q && ctrl_q.cmp_en;
    endsequence

    sequence s_no_clear;
        !(wr_stat && hwdata[pcc_pkg::STAT_MATCH_BIT]);
    endsequence

    event_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_EVENT) and s_cnt_moved and
        (cnt_q[15:0] == cmp_q[15:0]) |=> stat_q[pcc_pkg::STAT_MATCH_BIT])
        else $error("event mode match did not set flag");

    stimer_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_TIMER) and s_cnt_moved and
        (cnt_q == cmp_q) |=> stat_q[pcc_pkg::STAT_MATCH_BIT])
        else $error("sensor timer match did not set flag");

    timer_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_TIMER) and s_cnt_moved and
        (cnt_q == cmp_q) |=> stat_q[pcc_pkg::STAT_MATCH_BIT])
        else $error("timer match did not set flag");

    stimer_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_TIMER) && match_evt && ctrl_q.int_en &&
        mask_q[pcc_pkg::STAT_MATCH_BIT] ##1 (ctrl_q.int_en && mask_q[0]) and s_no_clear
        |=> position_unit_irq)
        else $error("match with enable did not raise irq");

    index_free_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode != pcc_pkg::MODE_ENCODER) && ctrl_q.idx_en && ctrl_q.int_en &&
        stat_q[0] && mask_q[0] |=> position_unit_irq)
        else $error("index enable gated the irq");

    upper_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wide && upd_q && ctrl_q.cmp_en && (cnt_q[15:0] == cmp_q[15:0]) |-> match_evt)
        else $error("upper compare bits took part in narrow mode");

    count_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && reg_hit(ra, pcc_pkg::COUNT_OFF) |=> hrdata[31:24] == 8'h00)
        else $error("count top byte not zero");

    enc_width_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_take && reg_hit(ra, pcc_pkg::COUNT_OFF) && !wide |=> hrdata[23:16] == 8'h00)
        else $error("encoder count wider than 16 bits");

    enc_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_ENCODER) && rotation_ccw && quadrature_count_pulse &&
        (cnt_q[15:0] == 16'h0000) && !wr_cnt |=> cnt_q == {8'h00, $past(period_q)})
        else $error("encoder down count did not reload");

    single_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wide && !quadrature_count_pulse |=> !match_evt)
        else $error("compare event without counter update");

    // ----------------------------------------------------------------
    // Counter, flag, interrupt and bus checks
    // ----------------------------------------------------------------
    // These compare the count across one edge, so they do not reuse the step logic.
    sequence s_pulse_step;
        quadrature_count_pulse && !wr_cnt;
    endsequence

    enc_up_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_ENCODER) && !rotation_ccw &&
        (cnt_q[15:0] == period_q) and s_pulse_step |=> cnt_q[15:0] == 16'h0000)
        else $error("encoder up count did not wrap to zero");

    enc_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_ENCODER) && rotation_ccw &&
        (cnt_q[15:0] != 16'h0000) and s_pulse_step |=>
        cnt_q[15:0] == $past(cnt_q[15:0]) - 16'h0001)
        else $error("encoder down count did not step by one");

    evt_up_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_EVENT) && !rotation_ccw &&
        (cnt_q[15:0] == 16'hffff) and s_pulse_step |=> cnt_q[15:0] == 16'h0000)
        else $error("event count did not wrap to zero");

    evt_down_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_EVENT) && rotation_ccw &&
        (cnt_q[15:0] == 16'h0000) and s_pulse_step |=> cnt_q[15:0] == 16'hffff)
        else $error("event count did not wrap to all ones");

    narrow_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !wide && !quadrature_count_pulse && !wr_cnt |=> $stable(cnt_q))
        else $error("narrow count moved without a pulse");

    timer_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_TIMER) && !wr_cnt |=>
        cnt_q == $past(cnt_q) + 24'h000001)
        else $error("timer count did not advance by one");

    stimer_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ctrl_q.mode == pcc_pkg::MODE_SENSOR_TIMER) and s_pulse_step |=>
        cnt_q == 24'h000000)
        else $error("sensor timer count not cleared by pulse");

    cnt_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cnt |=> cnt_q == $past(hwdata[pcc_pkg::CNT_W-1:0]))
        else $error("count write did not land");

    flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stat_q[pcc_pkg::STAT_MATCH_BIT] and s_no_clear |=> stat_q[pcc_pkg::STAT_MATCH_BIT])
        else $error("match flag dropped without a clear");

    set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
        match_evt && wr_stat && hwdata[pcc_pkg::STAT_MATCH_BIT] |=> stat_q[0])
        else $error("clear won over a compare event");

    cmp_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q.cmp_en && !stat_q[pcc_pkg::STAT_MATCH_BIT] |=> !stat_q[0])
        else $error("match flag set with compare disabled");

    irq_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(|(stat_q & mask_q)) |=> !position_unit_irq)
        else $error("irq raised with no unmasked status bit");

    irq_inten_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !ctrl_q.int_en &&
        !(stat_q[pcc_pkg::STAT_PULSE_BIT] && mask_q[pcc_pkg::STAT_PULSE_BIT])
        |=> !position_unit_irq)
        else $error("irq raised with interrupt enable off");

    bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> hreadyout && !hresp)
        else $error("bus slave not ready or not okay");

endmodule

// file: dv/pcc_sensor_model.sv
// Behavioural model of the position sensor front end that issues count pulses.
`timescale 1ns/1ps
module pcc_sensor_model (
    // Clock
    input  wire logic hclk,
    // Pulse and direction towards the block
    output logic      quadrature_count_pulse,
    output logic      rotation_ccw
);
    initial begin
        quadrature_count_pulse = 1'b0;
        rotation_ccw           = 1'b0;
    end

    // Direction settles one cycle before each pulse, so a reversal never lands on a pulse.
    // The gap sets the pulse rate, from one pulse every third cycle to slow rotation.
    task automatic step(input int n, input logic ccw, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            rotation_ccw <= ccw;
            @(posedge hclk);
            quadrature_count_pulse <= 1'b1;
            @(posedge hclk);
            quadrature_count_pulse <= 1'b0;
            repeat (gap) @(posedge hclk);
        end
    endtask
endmodule

// file: dv/position_compare_counter_tb.sv
// Self-checking testbench of the position compare counter.
`timescale 1ns/1ps
module position_compare_counter_tb;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pulse;
    logic        ccw;
    logic        irq;
    logic        rd_phase;
    logic [31:0] exp_q[$];
    logic [31:0] seed;
    int          bad_count;
    int          comparisons;

    pcc_position_compare_counter pcc_position_compare_counter_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .quadrature_count_pulse(pulse), .rotation_ccw(ccw), .position_unit_irq(irq));

    pcc_sensor_model pcc_sensor_model_inst (
        .hclk(hclk), .quadrature_count_pulse(pulse), .rotation_ccw(ccw));

    initial hclk = 1'b0;
    always #10 hclk = ~hclk;

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // The address phase holds until hready is seen high; read data is taken at the next one.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans   <= 2'h0;
        hwdata   <= d;
        rd_phase <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_phase <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, a, 32'h00000000);
    endtask

    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge hclk);
    endtask

    task automatic irq_is(input logic v);
        check({31'h00000000, irq}, {31'h00000000, v});
    endtask

    // The oldest noted read result is compared at the edge that ends its data phase.
    always @(posedge hclk) if (rd_phase === 1'b1) check(hrdata, exp_q.pop_front());
    always @(posedge hclk) if (rd_phase === 1'b1) begin
        check({30'h00000000, hreadyout, hresp}, 32'h00000002);
    end

    initial begin
        repeat (5000) @(posedge hclk);
        bad_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] offs[7];
        offs = '{pcc_pkg::CTRL_OFF, pcc_pkg::PERIOD_OFF, pcc_pkg::COMPARE_OFF,
                 pcc_pkg::COUNT_OFF, pcc_pkg::STATUS_OFF, pcc_pkg::MASK_OFF, 8'h18};
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, rd_phase} = '0;
        hsize = pcc_pkg::HSIZE_WORD;
        seed = 32'ha0f3f2ff;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 7; i++) rd(offs[i], 32'h00000000);
        wr(8'h18, 32'hffffffff);
        rd(8'h18, 32'h00000000);
        irq_is(1'b0);
        wr(pcc_pkg::COUNT_OFF, 32'hffffffff);
        rd(pcc_pkg::COUNT_OFF, 32'h0000ffff);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(pcc_pkg::COMPARE_OFF, seed);
            rd(pcc_pkg::COMPARE_OFF, seed & 32'h00ffffff);
        end
        // Encoder mode: down-count reloads the period after zero, up-count wraps to zero.
        wr(pcc_pkg::PERIOD_OFF, 32'h00000003);
        wr(pcc_pkg::COUNT_OFF, 32'h00000000);
        pcc_sensor_model_inst.step(1, 1'b1, 0);
        rd(pcc_pkg::COUNT_OFF, 32'h00000003);
        pcc_sensor_model_inst.step(1, 1'b0, 3);
        rd(pcc_pkg::COUNT_OFF, 32'h00000000);
        // Event count with index enable set and junk in the upper compare bits.
        wr(pcc_pkg::MASK_OFF, 32'h00000001);
        wr(pcc_pkg::STATUS_OFF, 32'h00000003);
        wr(pcc_pkg::COMPARE_OFF, 32'h00ab0005);
        wr(pcc_pkg::CTRL_OFF, 32'h0000001d);
        wr(pcc_pkg::COUNT_OFF, 32'h00000002);
        irq_is(1'b0);
        pcc_sensor_model_inst.step(3, 1'b0, 1);
        wait_irq(4);
        irq_is(1'b1);
        rd(pcc_pkg::STATUS_OFF, 32'h00000003);
        rd(pcc_pkg::COUNT_OFF, 32'h00000005);
        wr(pcc_pkg::STATUS_OFF, 32'h00000003);
        repeat (4) @(posedge hclk);
        irq_is(1'b0);
        rd(pcc_pkg::STATUS_OFF, 32'h00000000);
        wr(pcc_pkg::COUNT_OFF, 32'h00000000);
        pcc_sensor_model_inst.step(1, 1'b1, 0);
        rd(pcc_pkg::COUNT_OFF, 32'h0000ffff);
        // Sensor timer count: the low half matching alone must not flag.
        wr(pcc_pkg::CTRL_OFF, 32'h0000000e);
        wr(pcc_pkg::COMPARE_OFF, 32'h00020005);
        wr(pcc_pkg::COUNT_OFF, 32'h00010000);
        wr(pcc_pkg::STATUS_OFF, 32'h00000003);
        repeat (40) @(posedge hclk);
        irq_is(1'b0);
        wr(pcc_pkg::COUNT_OFF, 32'h00020000);
        wait_irq(20);
        irq_is(1'b1);
        rd(pcc_pkg::STATUS_OFF, 32'h00000001);
        // Timer mode across the 24-bit wrap, then interrupt enable and mask.
        wr(pcc_pkg::CTRL_OFF, 32'h00000007);
        wr(pcc_pkg::STATUS_OFF, 32'h00000003);
        wr(pcc_pkg::COMPARE_OFF, 32'h00000001);
        wr(pcc_pkg::COUNT_OFF, 32'h00fffffe);
        repeat (10) @(posedge hclk);
        irq_is(1'b0);
        rd(pcc_pkg::STATUS_OFF, 32'h00000001);
        wr(pcc_pkg::CTRL_OFF, 32'h0000000f);
        wait_irq(4);
        irq_is(1'b1);
        wr(pcc_pkg::MASK_OFF, 32'h00000000);
        repeat (3) @(posedge hclk);
        irq_is(1'b0);
        wr(pcc_pkg::STATUS_OFF, 32'h00000001);
        rd(pcc_pkg::STATUS_OFF, 32'h00000000);
        repeat (2) @(posedge hclk);
        conclude();
    end
endmodule
